// ===== rtl/phy_coding.sv
// Our own choices: the APB register port and the address map.
`default_nettype none
`include "phy_coding_map.svh"
module phy_coding #(
   parameter int XO_WAIT = `XO_WAIT_CYC
) (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       psel,
   input  wire logic       penable,
   input  wire logic       pwrite,
   input  wire logic [7:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]     prdata,
   output logic            pready,
   output logic            pslverr,
   input  wire logic       chip_power_down_n,
   input  wire logic       line_clk,
   input  wire logic       sd_above_low,
   input  wire logic       sd_above_high,
   input  wire logic       fiber_speed_select,
   input  wire logic       fiber_rx,
   input  wire logic [1:0] cu_pair1_rx,
   input  wire logic [1:0] cu_pair2_rx,
   input  wire logic       tx_en,
   input  wire logic [3:0] tx_data,
   output logic            tx_take,
   output logic            rx_dv,
   output logic            rx_er,
   output logic            rx_stb,
   output logic [3:0]      rx_data,
   output logic            rx_clk10,
   output logic            rx_bit10,
   output logic [1:0]      cu_pair1_tx,
   output logic [1:0]      cu_pair2_tx,
   output logic            fiber_tx,
   output logic            mdix,
   output logic            an_enable,
   output logic            speed_100,
   output logic            full_duplex,
   output logic            pause_allow,
   output logic            far_end_fault,
   output logic            fiber_pd,
   output logic            copper_pd,
   output logic            chip_off,
   output logic [1:0]      led_drive
);
   function automatic logic [4:0] enc(input logic [3:0] n);
      case (n)
         4'h0: enc = 5'h1e;  4'h1: enc = 5'h09;  4'h2: enc = 5'h14;  4'h3: enc = 5'h15;
         4'h4: enc = 5'h0a;  4'h5: enc = 5'h0b;  4'h6: enc = 5'h0e;  4'h7: enc = 5'h0f;
         4'h8: enc = 5'h12;  4'h9: enc = 5'h13;  4'ha: enc = 5'h16;  4'hb: enc = 5'h17;
         4'hc: enc = 5'h1a;  4'hd: enc = 5'h1b;  4'he: enc = 5'h1c;  default: enc = 5'h1d;
      endcase
   endfunction

   // returns {valid, nibble}
   function automatic logic [4:0] dec(input logic [4:0] g);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 0; i < 16; i++) begin
         if (enc(4'(i)) == g) r = {1'b1, 4'(i)};
      end
      return r;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return a <= `REG_STAT_OFF && a[1:0] == 2'h0;
   endfunction

   // pins: 0 pdn, 1 clk, 2 sd low, 3 sd high, 4 speed, 5 fiber rx, 7:6 pair1, 9:8 pair2
   logic [9:0] pin_s1_r, pin_s2_r;
   logic       clk_d_r;
   always_ff @(posedge mclk) begin
      if (rst) begin
         // power-down pin rests high: a low reset value would fake a power-down after reset
         pin_s1_r <= 10'h001;
         pin_s2_r <= 10'h001;
         clk_d_r  <= 1'b0;
      end else begin
         pin_s1_r <= {cu_pair2_rx, cu_pair1_rx, fiber_rx, fiber_speed_select,
                      sd_above_high, sd_above_low, line_clk, chip_power_down_n};
         pin_s2_r <= pin_s1_r;
         clk_d_r  <= pin_s2_r[1];
      end
   end
   logic tick;
   assign tick = pin_s2_r[1] & ~clk_d_r;

   logic reg_rst;
   assign reg_rst = rst | ~pin_s2_r[0];

   phy_coding_pkg::sd_class_t sd_class;
   always_comb begin
      if (pin_s2_r[3])      sd_class = phy_coding_pkg::sd_signal;
      else if (pin_s2_r[2]) sd_class = phy_coding_pkg::sd_fault;
      else                  sd_class = phy_coding_pkg::sd_none;
   end

   // registers
   logic [15:0] fbc_r, fc4_r, cbc_r, cc4_r, atc_r;
   logic        acc;
   assign acc = psel & penable & pready;
   always_ff @(posedge mclk) begin
      if (reg_rst) begin
         fbc_r <= `BC_RST;
         fc4_r <= `C4_RST;
         cbc_r <= `BC_RST;
         cc4_r <= `C4_RST;
         atc_r <= `ATC_RST;
      end else if (acc && pwrite) begin
         case (paddr)
            `REG_FBC_OFF: fbc_r <= pwdata[15:0];
            `REG_FC4_OFF: fc4_r <= pwdata[15:0];
            `REG_CBC_OFF: cbc_r <= pwdata[15:0];
            `REG_CC4_OFF: cc4_r <= pwdata[15:0];
            `REG_ATC_OFF: atc_r <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   logic fiber, fef_on, halt, dsc_lock_r, in_frame_r;
   assign fiber  = sd_class != phy_coding_pkg::sd_none;
   assign fef_on = sd_class == phy_coding_pkg::sd_fault &&
                   !fbc_r[`BC_FEF_DIS] && !fc4_r[`C4_FEF_DIS];
   assign halt   = reg_rst | (fiber ? fiber_pd : copper_pd);

   logic [31:0] rd_val;
   always_comb begin
      case (paddr)
         `REG_FBC_OFF:  rd_val = {16'h0000, fbc_r};
         `REG_FC4_OFF:  rd_val = {16'h0000, fc4_r};
         `REG_CBC_OFF:  rd_val = {16'h0000, cbc_r};
         `REG_CC4_OFF:  rd_val = {16'h0000, cc4_r};
         `REG_ATC_OFF:  rd_val = {16'h0000, atc_r};
         `REG_STAT_OFF: rd_val = {26'h0000000, in_frame_r, dsc_lock_r, mdix,
                                  far_end_fault, fiber, sd_class == phy_coding_pkg::sd_signal};
         default:       rd_val = 32'h00000000;
      endcase
   end

   // one wait state: ready is registered at the end of the first access cycle and seen in the second
   always_ff @(posedge mclk) begin
      if (rst) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
         if (psel && penable && !pready) begin
            prdata  <= pwrite ? 32'h00000000 : rd_val;
            pslverr <= ~mapped(paddr);
         end
      end
   end

   // port modes
   always_ff @(posedge mclk) begin
      if (reg_rst) begin
         an_enable     <= 1'b0;
         speed_100     <= 1'b0;
         full_duplex   <= 1'b0;
         pause_allow   <= 1'b0;
         far_end_fault <= 1'b0;
         fiber_pd      <= 1'b0;
         copper_pd     <= 1'b0;
         led_drive     <= 2'h0;
      end else begin
         an_enable     <= ~fiber & cbc_r[`BC_AN_EN];
         speed_100     <= fiber ? pin_s2_r[4] : (cbc_r[`BC_AN_EN] | cbc_r[`BC_SPEED]);
         full_duplex   <= fiber ? fbc_r[`BC_DUPLEX] : cbc_r[`BC_DUPLEX];
         pause_allow   <= (fiber ? fc4_r[`C4_FLOW] & fbc_r[`BC_DUPLEX]
                                 : cc4_r[`C4_FLOW] & cbc_r[`BC_DUPLEX]);
         far_end_fault <= fef_on;
         fiber_pd      <= fbc_r[`PD_BIT] | fc4_r[`PD_BIT];
         copper_pd     <= cbc_r[`PD_BIT] | cc4_r[`PD_BIT];
         led_drive     <= atc_r[`ATC_LED_LO+1:`ATC_LED_LO];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) chip_off <= 1'b0;
      else     chip_off <= ~pin_s2_r[0];
   end

   // transmit
   phy_coding_pkg::tx_state_t tx_state_r, tx_state_nxt;
   logic [4:0]  grp_r, grp_nxt;
   logic [2:0]  bit_cnt_r;
   logic [6:0]  fef_cnt_r;
   logic [10:0] scr_r;
   logic        nrzi_r, take_nxt, fef_idle, tx_nrz, scr_key, tx_scr;
   logic [1:0]  mlt_ph_r, mlt_lvl;

   always_comb begin
      tx_state_nxt = tx_state_r;
      grp_nxt      = `CG_IDLE;
      take_nxt     = 1'b0;
      case (tx_state_r)
         phy_coding_pkg::tx_idle: if (tx_en) begin
            tx_state_nxt = phy_coding_pkg::tx_j;
            grp_nxt      = `CG_J;
         end
         phy_coding_pkg::tx_j: begin
            tx_state_nxt = phy_coding_pkg::tx_k;
            grp_nxt      = `CG_K;
         end
         phy_coding_pkg::tx_k, phy_coding_pkg::tx_data: begin
            if (tx_en) begin
               tx_state_nxt = phy_coding_pkg::tx_data;
               grp_nxt      = enc(tx_data);
               take_nxt     = 1'b1;
            end else begin
               tx_state_nxt = phy_coding_pkg::tx_t;
               grp_nxt      = `CG_T;
            end
         end
         phy_coding_pkg::tx_t: begin
            tx_state_nxt = phy_coding_pkg::tx_r;
            grp_nxt      = 5'h07;
         end
         default: tx_state_nxt = phy_coding_pkg::tx_idle;
      endcase
   end

   assign fef_idle = fiber && fef_on && tx_state_r == phy_coding_pkg::tx_idle;
   assign tx_nrz   = fef_idle ? (fef_cnt_r != `FEF_ONES) : grp_r[4];
   assign scr_key  = scr_r[10] ^ scr_r[8];
   assign tx_scr   = fiber ? tx_nrz : tx_nrz ^ scr_key;

   always_ff @(posedge mclk) begin
      if (halt) begin
         tx_state_r <= phy_coding_pkg::tx_idle;
         grp_r      <= `CG_IDLE;
         bit_cnt_r  <= 3'h0;
         tx_take    <= 1'b0;
      end else begin
         tx_take <= 1'b0;
         if (tick) begin
            if (bit_cnt_r == 3'h4) begin
               tx_state_r <= tx_state_nxt;
               grp_r      <= grp_nxt;
               tx_take    <= take_nxt;
               bit_cnt_r  <= 3'h0;
            end else begin
               grp_r     <= {grp_r[3:0], 1'b0};
               bit_cnt_r <= bit_cnt_r + 3'h1;
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (halt) begin
         fef_cnt_r <= 7'h00;
         scr_r     <= `SCR_SEED;
         nrzi_r    <= 1'b0;
         mlt_ph_r  <= 2'h0;
      end else if (tick) begin
         if (fef_idle) fef_cnt_r <= (fef_cnt_r == `FEF_ONES) ? 7'h00 : fef_cnt_r + 7'h01;
         else          fef_cnt_r <= 7'h00;
         if (!fiber) scr_r <= {scr_r[9:0], scr_key};
         nrzi_r <= nrzi_r ^ tx_scr;
         if (!fiber && tx_scr) mlt_ph_r <= mlt_ph_r + 2'h1;
      end
   end

   always_comb begin
      case (mlt_ph_r)
         2'h1:    mlt_lvl = `LVL_PLUS;
         2'h3:    mlt_lvl = `LVL_MINUS;
         default: mlt_lvl = `LVL_ZERO;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (halt) begin
         cu_pair1_tx <= `LVL_ZERO;
         cu_pair2_tx <= `LVL_ZERO;
         fiber_tx    <= 1'b0;
      end else begin
         cu_pair1_tx <= (fiber || mdix) ? `LVL_ZERO : mlt_lvl;
         cu_pair2_tx <= (fiber || !mdix) ? `LVL_ZERO : mlt_lvl;
         fiber_tx    <= fiber & nrzi_r;
      end
   end

   // receive
   logic [1:0]  rx_lvl, lvl_d_r;
   logic        rx_nrzi_r, nrzi_now, rx_nrz, dkey, plain;
   logic [10:0] dsc_r;
   logic [4:0]  lock_cnt_r, dgrp;
   logic [8:0]  sh_r;
   logic [2:0]  rx_cnt_r;
   assign rx_lvl   = mdix ? pin_s2_r[7:6] : pin_s2_r[9:8];
   assign nrzi_now = fiber ? pin_s2_r[5] : (rx_lvl != lvl_d_r) ^ rx_nrzi_r;
   assign rx_nrz   = nrzi_now ^ rx_nrzi_r;
   assign dkey     = dsc_r[10] ^ dsc_r[8];
   assign plain    = fiber ? rx_nrz : rx_nrz ^ dkey;
   assign dgrp     = dec({sh_r[3:0], plain});

   // descrambler locks by assuming idle ones while it trains
   always_ff @(posedge mclk) begin
      if (halt) begin
         lvl_d_r    <= `LVL_ZERO;
         rx_nrzi_r  <= 1'b0;
         dsc_r      <= `SCR_SEED;
         lock_cnt_r <= 5'h00;
         dsc_lock_r <= 1'b0;
      end else if (tick) begin
         lvl_d_r   <= rx_lvl;
         rx_nrzi_r <= nrzi_now;
         if (fiber) begin
            // unscrambled fiber idle would train the descrambler to all zeros
            dsc_r      <= `SCR_SEED;
            lock_cnt_r <= 5'h00;
            dsc_lock_r <= 1'b0;
         end else begin
            dsc_r <= {dsc_r[9:0], dsc_lock_r ? dkey : ~rx_nrz};
            if (!dsc_lock_r) begin
               lock_cnt_r <= (~rx_nrz == dkey) ? lock_cnt_r + 5'h01 : 5'h00;
               dsc_lock_r <= lock_cnt_r == `DSC_LOCK;
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (halt) begin
         sh_r       <= 9'h000;
         in_frame_r <= 1'b0;
         rx_cnt_r   <= 3'h0;
         rx_dv      <= 1'b0;
         rx_er      <= 1'b0;
         rx_stb     <= 1'b0;
         rx_data    <= 4'h0;
      end else begin
         rx_stb <= 1'b0;
         if (tick && (fiber || dsc_lock_r)) begin
            sh_r <= {sh_r[7:0], plain};
            if (!in_frame_r) begin
               rx_er <= 1'b0;
               if ({sh_r, plain} == `JK_PAIR) begin
                  in_frame_r <= 1'b1;
                  rx_cnt_r   <= 3'h0;
               end
            end else if (rx_cnt_r != 3'h4) begin
               rx_cnt_r <= rx_cnt_r + 3'h1;
            end else begin
               rx_cnt_r <= 3'h0;
               if ({sh_r[3:0], plain} == `CG_T || {sh_r[3:0], plain} == `CG_IDLE) begin
                  in_frame_r <= 1'b0;
                  rx_dv      <= 1'b0;
                  rx_er      <= {sh_r[3:0], plain} == `CG_IDLE;
               end else begin
                  rx_dv   <= 1'b1;
                  rx_data <= dgrp[3:0];
                  rx_er   <= ~dgrp[4];
                  rx_stb  <= 1'b1;
               end
            end
         end
      end
   end

   // 10 Mb/s: line clock carries two half bits per data bit
   logic half_r;
   always_ff @(posedge mclk) begin
      if (halt) begin
         rx_clk10 <= 1'b0;
         half_r   <= 1'b0;
         rx_bit10 <= 1'b0;
      end else if (tick) begin
         rx_clk10 <= ~rx_clk10;
         half_r   <= ~half_r;
         if (half_r && !speed_100)
            rx_bit10 <= fiber ? pin_s2_r[5] : rx_lvl == `LVL_PLUS;
      end
   end

   // crossover: flip pairs after a quiet spell on the receive pair
   logic [$clog2(XO_WAIT+1)-1:0] quiet_r;
   always_ff @(posedge mclk) begin
      if (halt) begin
         quiet_r <= '0;
         mdix    <= 1'b0;
      end else if (fiber) begin
         quiet_r <= '0;
         mdix    <= 1'b0;
      end else if (cc4_r[`C4_XO_DIS]) begin
         quiet_r <= '0;
         mdix    <= cc4_r[`C4_XO_FORCE];
      end else if (tick && rx_lvl != lvl_d_r) begin
         quiet_r <= '0;
      end else if (quiet_r == ($clog2(XO_WAIT+1))'(XO_WAIT)) begin
         quiet_r <= '0;
         if (!cc4_r[`C4_XO_STD] || scr_r[0]) mdix <= ~mdix;
      end else begin
         quiet_r <= quiet_r + 1'b1;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   fiber_bypass_a: assert property (fiber && tick && !halt
                    |=> scr_r == $past(scr_r) && mlt_ph_r == $past(mlt_ph_r))
      else $error("fiber path was scrambled");
   fef_zero_a: assert property (fef_idle && tick && !halt && fef_cnt_r == `FEF_ONES
                 |=> nrzi_r == $past(nrzi_r))
      else $error("fault pattern lacks its zero");
   fef_ones_a: assert property (fef_idle && tick && !halt && fef_cnt_r < `FEF_ONES
                 |=> nrzi_r != $past(nrzi_r))
      else $error("fault pattern lacks a one");
   lfsr_alive_a: assert property (scr_r != 11'h000)
      else $error("scrambler stuck at zero");
   fiber_no_an_a: assert property (fiber && !halt |=> !an_enable && !mdix)
      else $error("fiber runs autoneg or crossover");
   pause_half_a: assert property (pause_allow |-> full_duplex)
      else $error("pause allowed in half duplex");
   pd_write_a: assert property (acc && pwrite && paddr == `REG_FBC_OFF
                 && pwdata[`PD_BIT] && pin_s2_r[0] |=> ##1 fiber_pd)
      else $error("port did not power down");
   chip_off_a: assert property (!pin_s2_r[0] |=> chip_off && !rx_dv && fiber_tx == 1'b0)
      else $error("chip power-down ignored");
   mdi_map_a: assert property (!halt && !fiber && !mdix |=> cu_pair2_tx == `LVL_ZERO)
      else $error("mdi drives the receive pair");
   speed_fix_a: assert property (fiber && !reg_rst |=> speed_100 == $past(pin_s2_r[4]))
      else $error("fiber speed not forced");
   apb_ready_a: assert property (psel && penable && !pready |=> pready)
      else $error("bus answer late");

   frame_start_c: cover property (tx_state_r == phy_coding_pkg::tx_j);
   rx_frame_c: cover property (!rx_dv ##1 rx_dv);
   fef_pattern_c: cover property (fef_idle && fef_cnt_r == `FEF_ONES && tick);
   mdix_flip_c: cover property (!mdix ##1 mdix);
endmodule
`default_nettype wire

// ===== rtl/phy_coding_map.svh
`ifndef PHY_CODING_MAP_SVH
`define PHY_CODING_MAP_SVH
`define REG_FBC_OFF  8'h00
`define REG_FC4_OFF  8'h04
`define REG_CBC_OFF  8'h08
`define REG_CC4_OFF  8'h0c
`define REG_ATC_OFF  8'h10
`define REG_STAT_OFF 8'h14
`define BC_FEF_DIS   2
`define BC_DUPLEX    8
`define BC_AN_EN     12
`define BC_SPEED     13
`define PD_BIT       11
`define C4_FEF_DIS   12
`define C4_XO_DIS    10
`define C4_XO_FORCE  9
`define C4_XO_STD    7
`define C4_FLOW      4
`define ATC_LED_LO   6
`define BC_RST       16'h3100
`define C4_RST       16'h0000
`define ATC_RST      16'h0040
`define FEF_ONES     7'h54
`define SCR_SEED     11'h7ff
`define DSC_LOCK     5'h14
`define CLK_MHZ      100
`define XO_WAIT_US   100
`define XO_WAIT_CYC  (`XO_WAIT_US * `CLK_MHZ)
`define CG_IDLE      5'h1f
`define CG_J         5'h18
`define CG_K         5'h11
`define CG_T         5'h0d
`define JK_PAIR      10'h311
`define LVL_ZERO     2'h0
`define LVL_PLUS     2'h1
`define LVL_MINUS    2'h3
`endif

// ===== rtl/phy_coding_pkg.sv
`default_nettype none
package phy_coding_pkg;
   typedef enum logic [2:0] {tx_idle, tx_j, tx_k, tx_data, tx_t, tx_r} tx_state_t;
   typedef enum logic [1:0] {sd_none, sd_fault, sd_signal} sd_class_t;
endpackage
`default_nettype wire

// ===== verif/link_partner.sv
`default_nettype none
module link_partner (
   input  wire logic [1:0] sd_class,
   input  wire logic       fiber_tx,
   input  wire logic [1:0] cu_pair1_tx,
   input  wire logic [1:0] cu_pair2_tx,
   output logic            line_clk,
   output logic            sd_above_low,
   output logic            sd_above_high,
   output logic            fiber_rx,
   output logic [1:0]      cu_pair1_rx,
   output logic [1:0]      cu_pair2_rx
);
   timeunit 1ns;
   timeprecision 1ps;
   // a live link carries idle codes between frames, so its bit clock never stops
   initial line_clk = 1'b0;
   always #62.5 line_clk = ~line_clk;
   // optical module: 0 empty socket, 1 module without light, 2 light seen
   assign sd_above_low  = sd_class != 2'd0;
   assign sd_above_high = sd_class == 2'd2;
   initial begin
      fiber_rx    = 1'b1;
      cu_pair1_rx = 2'b00;
      cu_pair2_rx = 2'b00;
   end
   // loopback plug: each transmit pair comes back on the other pair one bit later
   always @(posedge line_clk) begin
      fiber_rx    <= fiber_tx;
      cu_pair1_rx <= cu_pair2_tx;
      cu_pair2_rx <= cu_pair1_tx;
   end
endmodule
`default_nettype wire

// ===== verif/test_phy_coding.sv
`default_nettype none
module test_phy_coding;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, rst, psel, penable, pwrite, pready, pslverr, chip_power_down_n;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, v;
   logic        line_clk, sd_above_low, sd_above_high, fiber_speed_select, fiber_rx;
   logic [1:0]  cu_pair1_rx, cu_pair2_rx, cu_pair1_tx, cu_pair2_tx, led_drive, sd_class;
   logic        tx_en, tx_take, rx_dv, rx_er, rx_stb, rx_clk10, fiber_tx, mdix, an_enable;
   logic        speed_100, full_duplex, pause_allow, far_end_fault, fiber_pd, copper_pd;
   logic        chip_off, e, p, rx_bit10;
   logic [3:0]  tx_data, rx_data;
   int          fails = 0, checks_done = 0, seed = 57684, ones, n;

   phy_coding #(.XO_WAIT(200)) dut_u (
      .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .chip_power_down_n, .line_clk, .sd_above_low, .sd_above_high, .fiber_speed_select,
      .fiber_rx, .cu_pair1_rx, .cu_pair2_rx, .tx_en, .tx_data, .tx_take, .rx_dv, .rx_er,
      .rx_stb, .rx_data, .rx_clk10, .rx_bit10, .cu_pair1_tx, .cu_pair2_tx, .fiber_tx,
      .mdix, .an_enable, .speed_100, .full_duplex, .pause_allow, .far_end_fault,
      .fiber_pd, .copper_pd, .chip_off, .led_drive);
   link_partner far_u (.sd_class, .fiber_tx, .cu_pair1_tx, .cu_pair2_tx, .line_clk,
      .sd_above_low, .sd_above_high, .fiber_rx, .cu_pair1_rx, .cu_pair2_rx);

   always #5 mclk = ~mclk;

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic hang;
      fails++;
      $display("[FAIL] %0t wait ran out", $time);
      final_report();
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic err);
      int k;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 40);
      if (k >= 40) hang();
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        err;
      apb(1'b1, a, d, r, err);
      // control outputs come from flops a cycle or two behind the write
      repeat (3) @(posedge mclk);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic ex);
      logic [31:0] r;
      logic        err;
      apb(1'b0, a, 32'h0, r, err);
      chk(err, ex);
      if (!ex) chk(r, x);
   endtask

   // length of the run of ones between the first two zeros on the fiber line
   task automatic fef_run(output int cnt);
      logic q;
      int   run, z;
      run = 0;
      z = 0;
      cnt = -1;
      @(negedge line_clk);
      q = fiber_tx;
      for (int i = 0; i < 400 && z < 2; i++) begin
         @(negedge line_clk);
         if (fiber_tx !== q) run++;
         else begin
            if (z == 1) cnt = run;
            z++;
            run = 0;
         end
         q = fiber_tx;
      end
   endtask

   task automatic frame(input int len);
      logic [3:0] sent[$];
      logic [3:0] got[$];
      int         a, b;
      for (int i = 0; i < len; i++) sent.push_back(4'($random(seed)));
      fork
         begin
            tx_data <= sent[0];
            tx_en <= 1'b1;
            for (int i = 0; i < len; i++) begin
               a = 0;
               do begin
                  @(posedge mclk);
                  a++;
               end while (tx_take !== 1'b1 && a < 3000);
               if (a >= 3000) hang();
               if (i + 1 < len) tx_data <= sent[i + 1];
               else tx_en <= 1'b0;
            end
         end
         begin
            b = 0;
            while (got.size() < len && b < 20000) begin
               @(posedge mclk);
               b++;
               if (rx_stb === 1'b1) got.push_back(rx_data);
            end
         end
      join
      if (got.size() < len) hang();
      for (int i = 0; i < len; i++) chk(got[i], sent[i]);
      $display("frame of %0d nibbles done", len);
   endtask

   initial begin
      mclk = 1'b0;
      rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      chip_power_down_n = 1'b1;
      fiber_speed_select = 1'b1;
      {tx_en, tx_data, sd_class} = '0;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      rdc(8'h00, 32'h3100, 1'b0);
      rdc(8'h04, 32'h0, 1'b0);
      rdc(8'h0c, 32'h0, 1'b0);
      rdc(8'h10, 32'h40, 1'b0);
      rdc(8'h18, 32'h0, 1'b1);
      rdc(8'h02, 32'h0, 1'b1);
      repeat (4) begin
         v = $random(seed);
         wr(8'h10, v);
         chk(led_drive, v[7:6]);
      end
      $display("test registers done");
      for (int c = 0; c < 3; c++) begin
         sd_class <= c[1:0];
         repeat (10) @(posedge mclk);
         apb(1'b0, 8'h14, 32'h0, v, e);
         chk(v[2:0], {c == 1, c != 0, c == 2});
         chk(far_end_fault, c == 1);
         if (c != 0) chk({an_enable, mdix}, 2'b00);
      end
      sd_class <= 2'd1;
      repeat (10) @(posedge mclk);
      fef_run(ones);
      chk(ones, 84);
      p = rx_clk10;
      n = 0;
      repeat (12) begin
         @(negedge line_clk);
         if (rx_clk10 !== p) n++;
         p = rx_clk10;
      end
      chk(n, 12);
      wr(8'h00, 32'h3104);
      chk(far_end_fault, 0);
      fef_run(ones);
      chk(ones, -1);
      wr(8'h00, 32'h3100);
      wr(8'h04, 32'h1000);
      chk(far_end_fault, 0);
      wr(8'h04, 32'h0);
      chk(far_end_fault, 1);
      $display("test far end fault done");
      sd_class <= 2'd2;
      wr(8'h04, 32'h10);
      chk({full_duplex, pause_allow}, 2'b11);
      wr(8'h00, 32'h1000);
      chk({an_enable, speed_100, full_duplex, pause_allow}, 4'b0100);
      fiber_speed_select <= 1'b0;
      repeat (10) @(posedge mclk);
      chk({an_enable, speed_100}, 2'b00);
      repeat (4) @(negedge line_clk);
      p = rx_bit10;
      n = 0;
      repeat (16) begin
         @(negedge line_clk);
         if (rx_bit10 !== p) n++;
         p = rx_bit10;
      end
      // idle ones toggle the line every bit, so every second bit shows one level
      chk(n, 0);
      fiber_speed_select <= 1'b1;
      wr(8'h00, 32'h3100);
      wr(8'h04, 32'h800);
      chk(fiber_pd, 1);
      wr(8'h04, 32'h0);
      chk(fiber_pd, 0);
      wr(8'h00, 32'h3900);
      chk(fiber_pd, 1);
      wr(8'h00, 32'h3100);
      chk(fiber_pd, 0);
      wr(8'h0c, 32'h800);
      chk(copper_pd, 1);
      wr(8'h0c, 32'h0);
      chk(copper_pd, 0);
      $display("test modes done");
      frame(8);
      sd_class <= 2'd0;
      wr(8'h0c, 32'h600);
      chk(mdix, 1);
      // descrambler must retrain on copper idle before the frame starts
      repeat (900) @(posedge mclk);
      frame(8);
      wr(8'h0c, 32'h400);
      chk(mdix, 0);
      repeat (900) @(posedge mclk);
      frame(6);
      wr(8'h10, 32'hc0);
      chip_power_down_n <= 1'b0;
      repeat (8) @(posedge mclk);
      chk(chip_off, 1);
      chip_power_down_n <= 1'b1;
      repeat (8) @(posedge mclk);
      chk(chip_off, 0);
      rdc(8'h10, 32'h40, 1'b0);
      $display("test power down done");
      final_report();
   end
endmodule
`default_nettype wire
